// >>> include/lic_pkg.sv
// Constants shared by the line interface common control block
package lic_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [5:0] IDX_COMMON_CONTROL_ONE = 6'h00;
   localparam logic [5:0] IDX_ERROR_COUNT_TWO = 6'h12;
   localparam logic [5:0] IDX_TEST_ONE = 6'h13;
   localparam logic [5:0] IDX_TEST_TWO = 6'h14;
   localparam logic [5:0] IDX_TEST_THREE = 6'h15;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
   localparam int ADDR_LSB = 2;
   // Field positions in common_control_one
   localparam int BIT_LINE_STANDARD_SELECT = 7;
   localparam int BIT_NONRETURN_FORMAT_ENABLE = 6;
   localparam int BIT_CARRIER_LOSS_ALT_CRITERIA = 5;
   localparam int BIT_ERROR_COUNTER_UPDATE = 4;
   localparam int BIT_JITTER_CLOCK_SOURCE_SELECT = 3;
   localparam int BIT_TX_CLOCK_TO_JITTER_CLOCK = 2;
   localparam int BIT_TX_CLOCK_TO_RX_CLOCK = 1;
   localparam int BIT_TX_CLOCK_LOSS_FAILOVER = 0;
   // Interrupt status bits
   localparam int IRQ_CARRIER_LOSS = 0;
   localparam int IRQ_TX_CLOCK_LOSS = 1;
   localparam int IRQ_VIOLATION = 2;
   localparam int IRQ_SNAPSHOT_DONE = 3;
   localparam int IRQ_W = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Carrier loss zero counts
   localparam logic [11:0] CL_ZEROS_E1 = 12'd255;
   localparam logic [11:0] CL_ZEROS_T1 = 12'd192;
   localparam logic [11:0] CL_ZEROS_E1_ALT = 12'd2048;
   localparam logic [11:0] CL_ZEROS_T1_ALT = 12'd1544;
   // Excessive zeros run lengths
   localparam logic [11:0] EXZ_ZEROS_E1 = 12'd4;
   localparam logic [11:0] EXZ_ZEROS_T1 = 12'd8;
   // Timing
   localparam int HCLK_PERIOD_NS = 8;
   localparam int TX_LOSS_NS = 5000;
   localparam int TX_LOSS_CYCLES = (TX_LOSS_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
   localparam int ERR_W = 8;
   // Synchroniser lane positions
   localparam int S_TXPOS = 0;
   localparam int S_TXNEG = 1;
   localparam int S_TXCLK = 2;
   localparam int S_MCLK = 3;
   localparam int S_PLL = 4;
   localparam int S_RXCLK = 5;
   localparam int S_LPOS = 6;
   localparam int S_LNEG = 7;
   localparam int S_CV = 8;
   localparam int S_W = 9;
endpackage

// >>> hw/lic_common_control.sv
// Common control register bank and clock/data steering of the line interface
`timescale 1ns/1ps
`default_nettype none

module lic_common_control #(
   parameter int TX_LOSS_CYCLES = lic_pkg::TX_LOSS_CYCLES,
   parameter int ERR_W = lic_pkg::ERR_W
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Clock sources
   input wire logic transmit_clock_in,
   input wire logic master_clock_in,
   input wire logic pll_clock_in,
   input wire logic recovered_clock_in,
   // Receive line side, decoded
   input wire logic line_rx_pos,
   input wire logic line_rx_neg,
   input wire logic code_violation,
   // Framer transmit data
   input wire logic tx_positive_data,
   input wire logic tx_negative_data,
   // Framer receive data and clocks
   output logic rx_positive_data,
   output logic rx_negative_data,
   output logic receive_clock_out,
   output logic jitter_attenuator_clock,
   output logic transmit_timing_clock,
   // Transmit line side
   output logic line_tx_pos,
   output logic line_tx_neg,
   // Status
   output logic receive_carrier_loss,
   output logic tx_clock_lost,
   output logic irq
);
   // Register state
   logic [7:0] ctrl;
   logic [7:0] test_reg [3];
   logic [lic_pkg::IRQ_W-1:0] irq_status;
   logic [lic_pkg::IRQ_W-1:0] irq_mask;
   logic [ERR_W-1:0] err_count;
   logic [ERR_W-1:0] err_latched;

   function automatic logic idx_mapped(input logic [5:0] idx);
      idx_mapped = (idx == lic_pkg::IDX_COMMON_CONTROL_ONE) ||
                   (idx >= lic_pkg::IDX_ERROR_COUNT_TWO && idx <= lic_pkg::IDX_TEST_THREE) ||
                   (idx == lic_pkg::IDX_IRQ_STATUS) || (idx == lic_pkg::IDX_IRQ_MASK);
   endfunction

   // Pin synchronisers
   wire logic [lic_pkg::S_W-1:0] pins = {code_violation, line_rx_neg, line_rx_pos,
      recovered_clock_in, pll_clock_in, master_clock_in, transmit_clock_in,
      tx_negative_data, tx_positive_data};
   logic [lic_pkg::S_W-1:0] sync1;
   logic [lic_pkg::S_W-1:0] sync2;
   genvar gi;
   generate
      for (gi = 0; gi < lic_pkg::S_W; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pins[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   // Control fields
   wire logic std_t1 = ctrl[lic_pkg::BIT_LINE_STANDARD_SELECT];
   wire logic nrz_mode = ctrl[lic_pkg::BIT_NONRETURN_FORMAT_ENABLE];
   wire logic cl_alt = ctrl[lic_pkg::BIT_CARRIER_LOSS_ALT_CRITERIA];
   wire logic ecu_bit = ctrl[lic_pkg::BIT_ERROR_COUNTER_UPDATE];
   wire logic ja_pll = ctrl[lic_pkg::BIT_JITTER_CLOCK_SOURCE_SELECT];
   wire logic tx_to_ja = ctrl[lic_pkg::BIT_TX_CLOCK_TO_JITTER_CLOCK];
   wire logic tx_to_rx = ctrl[lic_pkg::BIT_TX_CLOCK_TO_RX_CLOCK];
   wire logic failover = ctrl[lic_pkg::BIT_TX_CLOCK_LOSS_FAILOVER];

   // Clock steering
   wire logic txclk_s = sync2[lic_pkg::S_TXCLK];
   wire logic ja_base = ja_pll ? sync2[lic_pkg::S_PLL] : sync2[lic_pkg::S_MCLK];
   wire logic ja_level = tx_to_ja ? txclk_s : ja_base;
   wire logic rx_level = tx_to_rx ? txclk_s : sync2[lic_pkg::S_RXCLK];
   wire logic tx_level = (failover && tx_clock_lost) ? ja_level : txclk_s;
   logic rx_level_d;
   logic tx_level_d;
   logic txclk_d;
   wire logic rx_edge = rx_level && !rx_level_d;
   wire logic tx_edge = tx_level && !tx_level_d;
   wire logic txclk_toggle = txclk_s ^ txclk_d;

   // Transmit clock watchdog; counts hclk cycles with no transmit clock change
   logic [15:0] tx_idle;
   wire logic tx_idle_full = tx_idle >= 16'(TX_LOSS_CYCLES);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_idle <= '0;
         tx_clock_lost <= 1'b0;
      end else begin
         tx_idle <= txclk_toggle ? '0 : (tx_idle_full ? tx_idle : tx_idle + 16'd1);
         tx_clock_lost <= !txclk_toggle && tx_idle_full;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_level_d <= 1'b0;
         tx_level_d <= 1'b0;
         txclk_d <= 1'b0;
         receive_clock_out <= 1'b0;
         jitter_attenuator_clock <= 1'b0;
         transmit_timing_clock <= 1'b0;
      end else begin
         rx_level_d <= rx_level;
         tx_level_d <= tx_level;
         txclk_d <= txclk_s;
         receive_clock_out <= rx_level;
         jitter_attenuator_clock <= ja_level;
         transmit_timing_clock <= tx_level;
      end
   end

   // Receive decode
   wire logic lpos = sync2[lic_pkg::S_LPOS];
   wire logic lneg = sync2[lic_pkg::S_LNEG];
   wire logic mark = lpos || lneg;
   logic last_pol;
   logic [11:0] zero_run;
   wire logic [11:0] cl_limit = cl_alt ? (std_t1 ? lic_pkg::CL_ZEROS_T1_ALT : lic_pkg::CL_ZEROS_E1_ALT)
                                       : (std_t1 ? lic_pkg::CL_ZEROS_T1 : lic_pkg::CL_ZEROS_E1);
   wire logic [11:0] exz_limit = std_t1 ? lic_pkg::EXZ_ZEROS_T1 : lic_pkg::EXZ_ZEROS_E1;
   wire logic bipolar_violation = mark && (lpos == last_pol);
   wire logic excessive_zeros = !mark && (zero_run == exz_limit - 12'd1);
   wire logic violation = rx_edge && (bipolar_violation || excessive_zeros || sync2[lic_pkg::S_CV]);
   wire logic cl_reach = rx_edge && !mark && (zero_run == cl_limit - 12'd1);
   wire logic [11:0] next_zero_run = mark ? '0 : ((zero_run >= cl_limit) ? zero_run : zero_run + 12'd1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_pol <= 1'b0;
         zero_run <= '0;
         receive_carrier_loss <= 1'b0;
         rx_positive_data <= 1'b0;
         rx_negative_data <= 1'b0;
      end else if (rx_edge) begin
         if (mark) begin
            last_pol <= lpos;
         end
         zero_run <= next_zero_run;
         receive_carrier_loss <= mark ? 1'b0 : (receive_carrier_loss || cl_reach);
         rx_positive_data <= nrz_mode ? mark : lpos;
         rx_negative_data <= nrz_mode ? (bipolar_violation || excessive_zeros || sync2[lic_pkg::S_CV]) : lneg;
      end
   end

   // Transmit encode; NRZ data are marked alternately on the two line outputs
   wire logic tx_nrz_bit = sync2[lic_pkg::S_TXPOS] || sync2[lic_pkg::S_TXNEG];
   logic tx_pol;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_pol <= 1'b0;
         line_tx_pos <= 1'b0;
         line_tx_neg <= 1'b0;
      end else if (tx_edge) begin
         if (nrz_mode) begin
            line_tx_pos <= tx_nrz_bit && !tx_pol;
            line_tx_neg <= tx_nrz_bit && tx_pol;
            tx_pol <= tx_pol ^ tx_nrz_bit;
         end else begin
            line_tx_pos <= sync2[lic_pkg::S_TXPOS];
            line_tx_neg <= sync2[lic_pkg::S_TXNEG];
         end
      end
   end

   // Error counter and snapshot; a request raised during a receive edge waits for the next one
   logic ecu_d;
   logic snap_req;
   wire logic ecu_rise = ecu_bit && !ecu_d;
   wire logic snap_now = snap_req && rx_edge;
   wire logic err_full = &err_count;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ecu_d <= 1'b0;
         snap_req <= 1'b0;
         err_count <= '0;
         err_latched <= '0;
      end else begin
         ecu_d <= ecu_bit;
         snap_req <= (snap_req && !rx_edge) || ecu_rise;
         if (snap_now) begin
            err_latched <= err_count;
            err_count <= ERR_W'(violation);
         end else if (violation && !err_full) begin
            err_count <= err_count + 1'b1;
         end
      end
   end

   // AHB-Lite slave: writes take no wait state, reads take one to register the data
   wire logic accept = hsel && htrans[1] && hready;
   wire logic [5:0] a_idx = haddr[lic_pkg::ADDR_LSB +: 6];
   logic w_pend;
   logic r_pend;
   logic [5:0] d_idx;
   wire logic wr_ok = w_pend && idx_mapped(d_idx);
   wire logic wr_ctrl = wr_ok && d_idx == lic_pkg::IDX_COMMON_CONTROL_ONE;
   wire logic wr_stat = wr_ok && d_idx == lic_pkg::IDX_IRQ_STATUS;
   wire logic wr_mask = wr_ok && d_idx == lic_pkg::IDX_IRQ_MASK;
   wire logic [lic_pkg::IRQ_W-1:0] irq_set;
   assign irq_set[lic_pkg::IRQ_CARRIER_LOSS] = cl_reach && !receive_carrier_loss;
   assign irq_set[lic_pkg::IRQ_TX_CLOCK_LOSS] = !txclk_toggle && tx_idle_full && !tx_clock_lost;
   assign irq_set[lic_pkg::IRQ_VIOLATION] = violation;
   assign irq_set[lic_pkg::IRQ_SNAPSHOT_DONE] = snap_now;
   wire logic [lic_pkg::IRQ_W-1:0] irq_clr = wr_stat ? hwdata[lic_pkg::IRQ_W-1:0] : '0;
   wire logic [lic_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;
   wire logic [31:0] rd_word =
      (d_idx == lic_pkg::IDX_COMMON_CONTROL_ONE) ? {24'h000000, ctrl} :
      (d_idx == lic_pkg::IDX_ERROR_COUNT_TWO) ? 32'(err_latched) :
      (d_idx == lic_pkg::IDX_TEST_ONE) ? {24'h000000, test_reg[0]} :
      (d_idx == lic_pkg::IDX_TEST_TWO) ? {24'h000000, test_reg[1]} :
      (d_idx == lic_pkg::IDX_TEST_THREE) ? {24'h000000, test_reg[2]} :
      (d_idx == lic_pkg::IDX_IRQ_STATUS) ? 32'(irq_status) :
      (d_idx == lic_pkg::IDX_IRQ_MASK) ? 32'(irq_mask) : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         w_pend <= 1'b0;
         r_pend <= 1'b0;
         d_idx <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
      end else begin
         w_pend <= accept && hwrite;
         r_pend <= accept && !hwrite;
         if (accept) begin
            d_idx <= a_idx;
         end
         hreadyout <= !(accept && !hwrite);
         hresp <= 1'b0;
         if (r_pend) begin
            hrdata <= rd_word;
         end
      end
   end

   generate
      for (gi = 0; gi < 3; gi++) begin : g_test
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               test_reg[gi] <= lic_pkg::RESET_BYTE;
            end else if (wr_ok && d_idx == lic_pkg::IDX_TEST_ONE + 6'(gi)) begin
               test_reg[gi] <= hwdata[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= lic_pkg::RESET_BYTE;
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= hwdata[7:0];
         end
         if (wr_mask) begin
            irq_mask <= hwdata[lic_pkg::IRQ_W-1:0];
         end
         irq_status <= next_irq_status;
         irq <= |(irq_status & irq_mask);
      end
   end

   // Checks
   a_bipolar_rx: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_edge && !nrz_mode |=> rx_positive_data == $past(lpos) && rx_negative_data == $past(lneg))
      else $error("bipolar receive data not passed through");
   a_nrz_violation: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_edge && nrz_mode && bipolar_violation |=> rx_negative_data && rx_positive_data)
      else $error("violation not flagged on negative receive output");
   a_loss_normal: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(receive_carrier_loss) && !$past(cl_alt) |->
      $past(zero_run) == ($past(std_t1) ? 12'd191 : 12'd254))
      else $error("carrier loss at wrong zero count");
   a_loss_alt: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(receive_carrier_loss) && $past(cl_alt) |->
      $past(zero_run) == ($past(std_t1) ? 12'd1543 : 12'd2047))
      else $error("alternate carrier loss at wrong zero count");
   a_snapshot_copy: assert property (@(posedge hclk) disable iff (!hresetn)
      snap_now |=> err_latched == $past(err_count) && err_count <= 1 && !snap_req)
      else $error("error count snapshot wrong");
   a_jitter_source: assert property (@(posedge hclk) disable iff (!hresetn)
      !tx_to_ja && !ja_pll && $stable(ctrl) |=> jitter_attenuator_clock == $past(sync2[lic_pkg::S_MCLK]))
      else $error("jitter clock not from master clock");
   a_rx_loop: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_to_rx && $stable(ctrl) |=> receive_clock_out == $past(txclk_s))
      else $error("receive clock not looped from transmit clock");
   a_no_failover: assert property (@(posedge hclk) disable iff (!hresetn)
      !failover |=> transmit_timing_clock == $past(txclk_s))
      else $error("transmit timing switched without failover");
   a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
      r_pend && !idx_mapped(d_idx) |=> hrdata == 32'h00000000 && hreadyout)
      else $error("absent register read not zero");
   a_read_ecr: assert property (@(posedge hclk) disable iff (!hresetn)
      r_pend && d_idx == lic_pkg::IDX_ERROR_COUNT_TWO |=> hrdata == 32'($past(err_latched)))
      else $error("error count two read mismatch");
endmodule

`default_nettype wire

// >>> dv/lic_framer_model.sv
// Framer model driving transmit clock and data toward the block
`timescale 1ns/1ps
`default_nettype none
module lic_framer_model (
   // Control from the bench
   input wire logic run,
   input wire logic [1:0] word,
   // Transmit side toward the block
   output logic clk_out,
   output logic pos_out,
   output logic neg_out
);
   initial begin
      clk_out = 1'b0;
      pos_out = 1'b0;
      neg_out = 1'b0;
   end
   // Only stops once low, so a stopped clock is a steady low level
   always begin
      #80;
      if (run || clk_out) begin
         clk_out = ~clk_out;
      end
   end
   // Data moves on the falling edge, away from the sampling edge
   always @(negedge clk_out) begin
      pos_out <= word[1];
      neg_out <= word[0];
   end
   // Released lines must not keep showing the last value
   always @(negedge run) begin
      pos_out <= ~pos_out;
      neg_out <= ~neg_out;
   end
endmodule
`default_nettype wire

// >>> dv/test_line_interface_common_control_one.sv
// Self-checking bench for the common control register bank
`timescale 1ns/1ps
`default_nettype none
module test_line_interface_common_control_one;
   typedef struct packed {logic [5:0] wi; logic [7:0] wd; logic [5:0] ri; logic [7:0] ex;} lic_row_t;
   logic hclk, hresetn, hsel, hwrite, master_clock_in, recovered_clock_in;
   logic line_rx_pos, line_rx_neg, run, viol, last_pos, cvio;
   logic [31:0] haddr, hwdata, r;
   logic [1:0] htrans, word, b, tx_prev;
   logic [1:0] q[$];
   int fails, tests_run, vexp, i, k;
   wire hreadyout, hresp, rx_positive_data, rx_negative_data, receive_clock_out;
   wire jitter_attenuator_clock, transmit_timing_clock, line_tx_pos, line_tx_neg;
   wire receive_carrier_loss, tx_clock_lost, irq, transmit_clock_in;
   wire tx_positive_data, tx_negative_data;
   wire [31:0] hrdata;
   // Internal clock runs in antiphase so that it can be told apart from the master clock
   wire pll_clock_in = ~master_clock_in;
   wire [6:0] srcs = {pll_clock_in, recovered_clock_in, master_clock_in, master_clock_in,
      transmit_clock_in, transmit_clock_in, transmit_clock_in};
   wire [6:0] dsts = {jitter_attenuator_clock, receive_clock_out, transmit_timing_clock,
      jitter_attenuator_clock, transmit_timing_clock, jitter_attenuator_clock,
      receive_clock_out};
   lic_row_t rows [8] = '{'{6'h13, 8'h5A, 6'h13, 8'h5A}, '{6'h14, 8'hA5, 6'h14, 8'hA5},
      '{6'h15, 8'hFF, 6'h15, 8'hFF}, '{6'h12, 8'h77, 6'h12, 8'h00},
      '{6'h16, 8'h33, 6'h13, 8'h5A}, '{6'h1F, 8'h44, 6'h16, 8'h00},
      '{6'h00, 8'h81, 6'h00, 8'h81}, '{6'h21, 8'h0A, 6'h21, 8'h0A}};
   logic [5:0] ridx [7] = '{6'h00, 6'h12, 6'h13, 6'h14, 6'h15, 6'h20, 6'h21};
   int cl_n [4] = '{255, 192, 2048, 1544};
   logic [7:0] cl_c [4] = '{8'h00, 8'h80, 8'h20, 8'hA0};
   logic [1:0] bits [4] = '{2'b10, 2'b10, 2'b01, 2'b01};

   lic_common_control #(.TX_LOSS_CYCLES(20)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .transmit_clock_in(transmit_clock_in), .master_clock_in(master_clock_in),
      .pll_clock_in(pll_clock_in), .recovered_clock_in(recovered_clock_in),
      .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg), .code_violation(cvio),
      .tx_positive_data(tx_positive_data), .tx_negative_data(tx_negative_data),
      .rx_positive_data(rx_positive_data), .rx_negative_data(rx_negative_data),
      .receive_clock_out(receive_clock_out), .jitter_attenuator_clock(jitter_attenuator_clock),
      .transmit_timing_clock(transmit_timing_clock), .line_tx_pos(line_tx_pos),
      .line_tx_neg(line_tx_neg), .receive_carrier_loss(receive_carrier_loss),
      .tx_clock_lost(tx_clock_lost), .irq(irq));

   lic_framer_model i_framer (.run(run), .word(word), .clk_out(transmit_clock_in),
      .pos_out(tx_positive_data), .neg_out(tx_negative_data));

   always #4 hclk = ~hclk;
   // Odd offsets keep the line clocks off the sampling edges
   initial begin
      #3;
      forever #80 recovered_clock_in = ~recovered_clock_in;
   end
   initial begin
      #5;
      forever #80 master_clock_in = ~master_clock_in;
   end

   // Line source: queued bits first, clean alternate marks when idle
   always @(negedge recovered_clock_in) begin
      @(posedge hclk);
      b = (q.size() > 0) ? q.pop_front() : (last_pos ? 2'b01 : 2'b10);
      viol = (b != 2'b00) && (b[1] == last_pos);
      if (viol) vexp++;
      if (b != 2'b00) last_pos = b[1];
      line_rx_pos <= b[1];
      line_rx_neg <= b[0];
   end

   task final_report;
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   task tmo;
      fails++;
      final_report;
   endtask

   task ahb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, idx, 2'b00};
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) tmo;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) tmo;
      r = hrdata;
      chk(32'(hresp), 32'h0);
   endtask

   task rx_wait;
      int n;
      for (n = 0; n < 60000 && q.size() > 0; n++) @(posedge hclk);
      if (q.size() > 0) tmo;
      @(posedge recovered_clock_in);
      repeat (6) @(posedge hclk);
   endtask

   task follow(input int s, input logic e);
      int n;
      for (n = 0; n < 100 && srcs[s] !== 1'b0; n++) @(posedge hclk);
      for (n = 0; n < 100 && srcs[s] !== 1'b1; n++) @(posedge hclk);
      if (srcs[s] !== 1'b1) tmo;
      repeat (6) @(posedge hclk);
      chk(32'(dsts[s]), 32'(e));
   endtask

   task chk_bit(input logic [1:0] bb, input logic nrz);
      q.push_back(bb);
      rx_wait;
      chk(32'(rx_positive_data), 32'(nrz | bb[1]));
      chk(32'(rx_negative_data), 32'(nrz ? viol : bb[0]));
   endtask

   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hwdata = 32'h0; master_clock_in = 1'b0; recovered_clock_in = 1'b0;
      line_rx_pos = 1'b0; line_rx_neg = 1'b0; run = 1'b1; word = 2'b10;
      last_pos = 1'b0; viol = 1'b0; fails = 0; tests_run = 0; vexp = 0; cvio = 1'b0;
      repeat (5) @(posedge hclk);
      chk(32'(hreadyout), 32'h1);
      chk(32'(irq), 32'h0);
      hresetn <= 1'b1;
      for (i = 0; i < 7; i++) begin
         ahb(1'b0, ridx[i], 8'h00);
         chk(r, 32'h0);
      end
      for (i = 0; i < 8; i++) begin
         ahb(1'b1, rows[i].wi, rows[i].wd);
         ahb(1'b0, rows[i].ri, 8'h00);
         chk(r, {24'h0, rows[i].ex});
      end
      ahb(1'b1, 6'h00, 8'h02);
      follow(0, 1'b1);
      ahb(1'b1, 6'h00, 8'h00);
      follow(5, 1'b1);
      ahb(1'b1, 6'h00, 8'h04);
      follow(1, 1'b1);
      ahb(1'b1, 6'h00, 8'h00);
      follow(3, 1'b1);
      ahb(1'b1, 6'h00, 8'h08);
      follow(3, 1'b0);
      follow(6, 1'b1);
      ahb(1'b1, 6'h21, 8'h00);
      ahb(1'b1, 6'h00, 8'h01);
      run <= 1'b0;
      repeat (60) @(posedge hclk);
      chk(32'(tx_clock_lost), 32'h1);
      follow(4, 1'b1);
      chk(32'(irq), 32'h0);
      ahb(1'b1, 6'h21, 8'h02);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h1);
      ahb(1'b0, 6'h20, 8'h00);
      chk(32'(r[1]), 32'h1);
      ahb(1'b1, 6'h20, 8'h02);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      ahb(1'b1, 6'h00, 8'h00);
      follow(4, 1'b0);
      run <= 1'b1;
      follow(2, 1'b1);
      chk(32'(tx_clock_lost), 32'h0);
      // The stop flipped the data lines; one falling edge must restore them first
      follow(2, 1'b1);
      chk(32'({line_tx_pos, line_tx_neg}), 32'h2);
      ahb(1'b1, 6'h00, 8'h40);
      word <= 2'b01;
      follow(2, 1'b1);
      tx_prev = {line_tx_pos, line_tx_neg};
      chk(32'(^tx_prev), 32'h1);
      follow(2, 1'b1);
      chk(32'({line_tx_pos, line_tx_neg}), 32'({tx_prev[0], tx_prev[1]}));
      ahb(1'b1, 6'h21, 8'h01);
      for (k = 0; k < 4; k++) begin
         ahb(1'b1, 6'h00, cl_c[k]);
         ahb(1'b1, 6'h20, 8'h0F);
         repeat (cl_n[k] - 1) q.push_back(2'b00);
         rx_wait;
         chk(32'(receive_carrier_loss), 32'h0);
         q.push_back(2'b00);
         rx_wait;
         chk(32'(receive_carrier_loss), 32'h1);
         chk(32'(irq), 32'h1);
         rx_wait;
         chk(32'(receive_carrier_loss), 32'h0);
      end
      for (k = 0; k < 2; k++) begin
         ahb(1'b1, 6'h00, k[0] ? 8'h40 : 8'h00);
         for (i = 0; i < 4; i++) chk_bit(bits[i], k[0]);
      end
      cvio <= 1'b1;
      rx_wait;
      chk(32'(rx_negative_data), 32'h1);
      cvio <= 1'b0;
      rx_wait;
      chk(32'(rx_negative_data), 32'h0);
      // Snapshot twice: the first clears the count, the second captures it
      for (k = 0; k < 2; k++) begin
         if (k == 1) begin
            vexp = 0;
            repeat (4) q.push_back(2'b10);
            rx_wait;
         end
         ahb(1'b1, 6'h00, 8'h40);
         ahb(1'b1, 6'h00, 8'h50);
         repeat (3) rx_wait;
      end
      ahb(1'b0, 6'h12, 8'h00);
      chk(r, 32'(vexp));
      final_report;
   end
endmodule
`default_nettype wire
